/* pkg/sfi_pkg.sv */
// shared constants and types of the sequencer flow and interrupt control block
package sfi_pkg;
	localparam int NUM_VEC = 30;
	localparam int NUM_HW  = 29;
	localparam logic [4:0] SW_VEC_IDX = 5'h1d;
	localparam logic [31:0] RET_STEP = 32'h0000_0004;

	typedef enum logic [3:0] {
		OP_NOP, OP_JUMP, OP_CALL, OP_LINK_RET, OP_LOOP0_NE, OP_LOOP1_NE,
		OP_LOOP0_EX, OP_LOOP1_EX, OP_ALIAS_STORE, OP_ALIAS_LOAD, OP_RTI,
		OP_RDS, OP_IRET_KEEP, OP_SW_EXC
	} sfi_op_e;

	typedef enum logic [1:0] {ST_IDLE, ST_VEC, ST_SAVE} sfi_state_e;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h04;
	localparam logic [7:0] OFS_LATCH_LO  = 8'h08;
	localparam logic [7:0] OFS_LATCH_HI  = 8'h0c;
	localparam logic [7:0] OFS_PMASK_LO  = 8'h10;
	localparam logic [7:0] OFS_PMASK_HI  = 8'h14;
	localparam logic [7:0] OFS_SEQ_STAT  = 8'h18;
	localparam logic [7:0] OFS_LINK      = 8'h1c;
	localparam logic [7:0] OFS_IRET      = 8'h20;
	localparam logic [7:0] OFS_SRET      = 8'h24;
	localparam logic [7:0] OFS_LC0       = 8'h28;
	localparam logic [7:0] OFS_LC1       = 8'h2c;
	localparam logic [7:0] OFS_EVT_STAT  = 8'h30;
	localparam logic [7:0] OFS_EVT_MASK  = 8'h34;
	localparam logic [7:0] OFS_VEC_BASE  = 8'h80;

	// field positions
	localparam int CTRL_HW_EN    = 0;
	localparam int CTRL_SW_EN    = 1;
	localparam int CTRL_VARIANT  = 2;
	localparam int BLOCK_BIT_PMH = 29;
	localparam int BLOCK_BIT_SQS = 21;
	localparam int SWEXC_BIT     = 0;
	localparam int EVT_HW        = 0;
	localparam int EVT_SW        = 1;
	localparam int EVT_LOOP      = 2;

	// reset values
	localparam logic [2:0]  CTRL_RST = 3'h0;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [2:0]  EVT_RST  = 3'h0;
endpackage

/* logic/sfi_vec_table.sv */
// register-held table of interrupt vector addresses
`timescale 1ns/100ps
module sfi_vec_table (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        wr_en,
	input  wire logic [4:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	input  wire logic [4:0]  rd_a_idx,
	output logic      [31:0] rd_a_data,
	input  wire logic [4:0]  rd_b_idx,
	output logic      [31:0] rd_b_data
);
	import sfi_pkg::*;

	typedef struct packed {
		logic [NUM_VEC-1:0][31:0] vec;
	} sfi_vt_s;

	sfi_vt_s s;
	sfi_vt_s next_s;

	function automatic logic [31:0] pick(sfi_vt_s t, logic [4:0] idx);
		pick = (idx < 5'(NUM_VEC)) ? t.vec[idx] : WORD_RST;
	endfunction

	always_comb begin
		next_s = s;
		if (wr_en && wr_idx < 5'(NUM_VEC)) begin
			next_s.vec[wr_idx] = wr_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rd_a_data = pick(s, rd_a_idx);
	assign rd_b_data = pick(s, rd_b_idx);
endmodule

/* logic/sfi_seq.sv */
// program flow and interrupt entry control of the sequencer
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps

// How it works
// - call writes return address into link register
// - link-return jumps to link register address
// - taken branch kills shadow, no delay slots
// - two loop counters, expired/not-expired tests
// - loop closes by jump while not expired
// - thirty vector registers inside the controller
// - hw entry: latch, fetch vector, save pc
// - hw entry sets pending-mask bit and global block
// - sw exception: latch, vector, pc to subroutine return
// - no nesting bit; hw entry blocks all hw interrupts, not the sw exception
// - alias store writes return address, clears block
// - alias load restores return address, sets block
// - return-from-interrupt resumes at interrupt return
// - reduce-to-subroutine clears in-service status
// - plain interrupt return keeps pending-mask bits
module sfi_seq (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic      [31:0]         hrdata,
	output logic                     hresp,
	input  wire logic [28:0]         irq_pin,
	input  wire logic [31:0]         cur_pc,
	input  wire logic                op_valid,
	input  wire sfi_pkg::sfi_op_e    op_code,
	input  wire logic [31:0]         op_target,
	input  wire logic [31:0]         op_load_data,
	output logic                     redirect_valid,
	output logic      [31:0]         redirect_addr,
	output logic                     store_valid,
	output logic      [31:0]         store_data,
	output logic                     entry_busy,
	output logic                     irq
);
	import sfi_pkg::*;

	typedef struct packed {
		logic              hreadyout;
		logic [31:0]       hrdata;
		logic              hresp;
		logic              pend;
		logic              pwrite;
		logic [7:0]        paddr;
		logic [2:0]        ctrl;
		logic [28:0]       irq_en;
		logic [31:0]       latch_lo;
		logic [31:0]       latch_hi;
		logic [31:0]       pmask_lo;
		logic [31:0]       pmask_hi;
		logic [31:0]       seq_stat;
		logic [31:0]       link;
		logic [31:0]       iret;
		logic [31:0]       sret;
		logic [31:0]       lc0;
		logic [31:0]       lc1;
		logic [2:0]        evt;
		logic [2:0]        evt_mask;
		logic              irq;
		sfi_state_e        state;
		logic              busy;
		logic              is_sw;
		logic [4:0]        cur_idx;
		logic [28:0]       sync1;
		logic [28:0]       sync2;
		logic              redirect_valid;
		logic [31:0]       redirect_addr;
		logic              store_valid;
		logic [31:0]       store_data;
	} sfi_seq_s;

	sfi_seq_s s;
	sfi_seq_s next_s;

	logic [31:0] vt_bus_data;
	logic [31:0] vt_seq_data;
	logic        vt_wr;

	// lowest set bit wins; valid flag in bit 5
	function automatic logic [5:0] lowest(logic [28:0] v);
		lowest = 6'h00;
		for (int i = NUM_HW - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest = {1'b1, 5'(i)};
			end
		end
	endfunction

	// a request is eligible only above every in-service level
	function automatic logic [28:0] eligible(logic [28:0] req, logic [28:0] pm);
		logic [28:0] below;
		below = '0;
		below[0] = pm[0];
		for (int i = 1; i < NUM_HW; i++) begin
			below[i] = below[i-1] | pm[i];
		end
		eligible = req & ~below;
	endfunction

	function automatic logic blocked(sfi_seq_s t);
		blocked = t.ctrl[CTRL_VARIANT] ? t.seq_stat[BLOCK_BIT_SQS] : t.pmask_hi[BLOCK_BIT_PMH];
	endfunction

	assign vt_wr = s.pend && s.pwrite && s.paddr[7];

	sfi_vec_table u_vt (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.wr_en     (vt_wr),
		.wr_idx    (s.paddr[6:2]),
		.wr_data   (hwdata),
		.rd_a_idx  (s.paddr[6:2]),
		.rd_a_data (vt_bus_data),
		.rd_b_idx  (s.cur_idx),
		.rd_b_data (vt_seq_data)
	);

	always_comb begin
		logic [5:0]  pick;
		logic [5:0]  svc;
		logic [2:0]  evt_set;
		logic [31:0] rd;
		pick = lowest(eligible(s.latch_lo[28:0] & s.irq_en, s.pmask_lo[28:0]));
		svc = lowest(s.pmask_lo[28:0]);
		evt_set = '0;
		rd = WORD_RST;
		next_s = s;
		next_s.redirect_valid = 1'b0;
		next_s.store_valid = 1'b0;
		next_s.sync1 = irq_pin;
		next_s.sync2 = s.sync1;

		// bus: one wait state, access done in the data phase
		if (s.pend) begin
			next_s.pend = 1'b0;
			next_s.hreadyout = 1'b1;
			if (s.paddr[7]) begin
				rd = vt_bus_data;
			end else begin
				unique case (s.paddr)
					OFS_CTRL:     rd = {29'h0, s.ctrl};
					OFS_IRQ_EN:   rd = {3'h0, s.irq_en};
					OFS_LATCH_LO: rd = s.latch_lo;
					OFS_LATCH_HI: rd = s.latch_hi;
					OFS_PMASK_LO: rd = s.pmask_lo;
					OFS_PMASK_HI: rd = s.pmask_hi;
					OFS_SEQ_STAT: rd = s.seq_stat;
					OFS_LINK:     rd = s.link;
					OFS_IRET:     rd = s.iret;
					OFS_SRET:     rd = s.sret;
					OFS_LC0:      rd = s.lc0;
					OFS_LC1:      rd = s.lc1;
					OFS_EVT_STAT: rd = {29'h0, s.evt};
					OFS_EVT_MASK: rd = {29'h0, s.evt_mask};
					default:      rd = WORD_RST;
				endcase
			end
			if (s.pwrite) begin
				unique case (s.paddr)
					OFS_CTRL:     next_s.ctrl = hwdata[2:0];
					OFS_IRQ_EN:   next_s.irq_en = hwdata[28:0];
					OFS_LC0:      next_s.lc0 = hwdata;
					OFS_LC1:      next_s.lc1 = hwdata;
					OFS_EVT_STAT: next_s.evt = s.evt & ~hwdata[2:0];
					OFS_EVT_MASK: next_s.evt_mask = hwdata[2:0];
					default:      next_s.evt = next_s.evt;
				endcase
			end else begin
				next_s.hrdata = rd;
			end
		end else if (hsel && hready && htrans[1]) begin
			next_s.pend = 1'b1;
			next_s.pwrite = hwrite;
			next_s.paddr = {haddr[7:2], 2'b00};
			next_s.hreadyout = 1'b0;
		end

		// pins latch while enabled, sticky until entry
		next_s.latch_lo[28:0] = s.latch_lo[28:0] | (s.sync2 & s.irq_en);

		unique case (s.state)
			ST_IDLE: begin
				if (op_valid && op_code == OP_SW_EXC && s.ctrl[CTRL_SW_EN]) begin
					if (s.ctrl[CTRL_VARIANT]) begin
						next_s.seq_stat[SWEXC_BIT] = 1'b1;
					end else begin
						next_s.latch_hi[SWEXC_BIT] = 1'b1;
					end
					next_s.is_sw = 1'b1;
					next_s.cur_idx = SW_VEC_IDX;
					next_s.state = ST_VEC;
				end else if (op_valid) begin
					unique case (op_code)
						OP_JUMP: begin
							next_s.redirect_valid = 1'b1;
							next_s.redirect_addr = op_target;
						end
						OP_CALL: begin
							next_s.link = cur_pc + RET_STEP;
							next_s.redirect_valid = 1'b1;
							next_s.redirect_addr = op_target;
						end
						OP_LINK_RET: begin
							next_s.redirect_valid = 1'b1;
							next_s.redirect_addr = s.link;
						end
						OP_LOOP0_NE: begin
							if (s.lc0 != WORD_RST) begin
								next_s.lc0 = s.lc0 - 32'h1;
							end
							next_s.redirect_valid = s.lc0 > 32'h1;
							next_s.redirect_addr = op_target;
							evt_set[EVT_LOOP] = s.lc0 <= 32'h1;
						end
						OP_LOOP1_NE: begin
							if (s.lc1 != WORD_RST) begin
								next_s.lc1 = s.lc1 - 32'h1;
							end
							next_s.redirect_valid = s.lc1 > 32'h1;
							next_s.redirect_addr = op_target;
							evt_set[EVT_LOOP] = s.lc1 <= 32'h1;
						end
						OP_LOOP0_EX: begin
							next_s.redirect_valid = s.lc0 == WORD_RST;
							next_s.redirect_addr = op_target;
						end
						OP_LOOP1_EX: begin
							next_s.redirect_valid = s.lc1 == WORD_RST;
							next_s.redirect_addr = op_target;
						end
						OP_ALIAS_STORE: begin
							next_s.store_valid = 1'b1;
							next_s.store_data = s.iret;
							next_s.pmask_hi[BLOCK_BIT_PMH] = s.ctrl[CTRL_VARIANT] & s.pmask_hi[BLOCK_BIT_PMH];
							next_s.seq_stat[BLOCK_BIT_SQS] = ~s.ctrl[CTRL_VARIANT] & s.seq_stat[BLOCK_BIT_SQS];
						end
						OP_ALIAS_LOAD: begin
							next_s.iret = op_load_data;
							next_s.pmask_hi[BLOCK_BIT_PMH] = ~s.ctrl[CTRL_VARIANT] | s.pmask_hi[BLOCK_BIT_PMH];
							next_s.seq_stat[BLOCK_BIT_SQS] = s.ctrl[CTRL_VARIANT] | s.seq_stat[BLOCK_BIT_SQS];
						end
						OP_RTI: begin
							next_s.redirect_valid = 1'b1;
							next_s.redirect_addr = s.iret;
							if (svc[5]) begin
								next_s.pmask_lo[svc[4:0]] = 1'b0;
							end
							next_s.pmask_hi[BLOCK_BIT_PMH] = 1'b0;
							next_s.seq_stat[BLOCK_BIT_SQS] = 1'b0;
						end
						OP_RDS: begin
							if (svc[5]) begin
								next_s.pmask_lo[svc[4:0]] = 1'b0;
							end
						end
						OP_IRET_KEEP: begin
							next_s.redirect_valid = 1'b1;
							next_s.redirect_addr = s.iret;
						end
						default: begin
							next_s.redirect_valid = 1'b0;
						end
					endcase
				end else if (s.ctrl[CTRL_HW_EN] && !blocked(s) && pick[5]) begin
					next_s.is_sw = 1'b0;
					next_s.cur_idx = pick[4:0];
					next_s.state = ST_VEC;
				end
			end
			ST_VEC: begin
				next_s.redirect_addr = vt_seq_data;
				next_s.state = ST_SAVE;
			end
			ST_SAVE: begin
				next_s.redirect_valid = 1'b1;
				next_s.state = ST_IDLE;
				if (s.is_sw) begin
					next_s.sret = cur_pc;
					evt_set[EVT_SW] = 1'b1;
				end else begin
					next_s.iret = cur_pc;
					// a fresh pin event in the save cycle survives the clear
					next_s.latch_lo[s.cur_idx] = s.sync2[s.cur_idx] & s.irq_en[s.cur_idx];
					next_s.pmask_lo[s.cur_idx] = 1'b1;
					// no nesting bit: entry always raises the block
					if (s.ctrl[CTRL_VARIANT]) begin
						next_s.seq_stat[BLOCK_BIT_SQS] = 1'b1;
					end else begin
						next_s.pmask_hi[BLOCK_BIT_PMH] = 1'b1;
					end
					evt_set[EVT_HW] = 1'b1;
				end
			end
		endcase

		// set wins over a same-cycle clear
		next_s.evt = next_s.evt | evt_set;
		next_s.irq = |(next_s.evt & next_s.evt_mask);
		next_s.busy = (next_s.state != ST_IDLE);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.hreadyout <= 1'b1;
			s.ctrl <= CTRL_RST;
			s.evt <= EVT_RST;
			s.evt_mask <= EVT_RST;
			s.state <= ST_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hrdata = s.hrdata;
	assign hresp = s.hresp;
	assign redirect_valid = s.redirect_valid;
	assign redirect_addr = s.redirect_addr;
	assign store_valid = s.store_valid;
	assign store_data = s.store_data;
	assign entry_busy = s.busy;
	assign irq = s.irq;
endmodule

/* sim/sfi_irq_src.sv */
// interrupt source model: raises one line for two cycles on request
`timescale 1ns/100ps
module sfi_irq_src (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        fire,
	input  wire logic [4:0]  idx,
	output logic      [28:0] irq_pin
);
	logic [1:0] cnt;
	logic [4:0] line;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt  <= 2'h0;
			line <= 5'h0;
		end else if (fire) begin
			cnt  <= 2'h2;
			line <= idx;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
	end
	assign irq_pin = (cnt != 2'h0) ? (29'h1 << line) : 29'h0;
endmodule

/* sim/sfi_seq_chk.sv */
// port assertions of the sequencer block
`timescale 1ns/100ps
module sfi_seq_chk
	import sfi_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [1:0]       htrans,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic             op_valid,
	input wire sfi_pkg::sfi_op_e op_code,
	input wire logic [31:0]      op_target,
	input wire logic             redirect_valid,
	input wire logic [31:0]      redirect_addr,
	input wire logic             store_valid,
	input wire logic             entry_busy
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire go = op_valid && !entry_busy;
	wire st_op = go && op_code == OP_ALIAS_STORE;
	sequence s_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence s_entry;
		entry_busy ##1 (!entry_busy && redirect_valid);
	endsequence
	AST_BUS: assert property (hsel && hready && htrans[1] |=> s_wait)
		else $error("bus wait state wrong");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	AST_CALL: assert property (go && op_code == OP_CALL |=>
		redirect_valid && redirect_addr == $past(op_target)) else $error("call redirect wrong");
	AST_JUMP: assert property (go && op_code == OP_JUMP |=>
		redirect_valid && redirect_addr == $past(op_target)) else $error("jump redirect wrong");
	AST_RET: assert property (go && op_code inside {OP_LINK_RET, OP_RTI, OP_IRET_KEEP}
		|=> redirect_valid) else $error("return without redirect");
	AST_STORE: assert property (store_valid |-> $past(st_op))
		else $error("store without alias store");
	AST_ENTRY: assert property ($rose(entry_busy) |=> s_entry)
		else $error("entry sequence wrong");
	AST_BUSY: assert property (op_valid && entry_busy |=> !store_valid)
		else $error("op taken during entry");
endmodule
bind sfi_seq sfi_seq_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp,
	.op_valid, .op_code, .op_target, .redirect_valid, .redirect_addr, .store_valid, .entry_busy);

/* sim/sfi_seq_tb_top.sv */
// self-checking bench of the sequencer block
`timescale 1ns/100ps
module sfi_seq_tb_top;
	import sfi_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, op_valid = 0, fire = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, cur_pc = 0, op_target = 0, op_load_data = 0;
	logic [4:0] idx = 0;
	sfi_op_e op_code = OP_NOP;
	wire hreadyout, hresp, redirect_valid, store_valid, entry_busy, irq;
	wire [31:0] hrdata, redirect_addr, store_data;
	wire [28:0] irq_pin;
	wire hready = hreadyout;
	logic [31:0] seed = 32'h08ab, rd, ra, sd, p, q, t, v[30];
	logic rv, sv;
	int n_errors = 0, num_checks = 0, cyc = 0, k, lc;
	always #50 hclk = ~hclk;
	sfi_irq_src u_src (.hclk, .hresetn, .fire, .idx, .irq_pin);
	sfi_seq uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .irq_pin, .cur_pc, .op_valid, .op_code,
		.op_target, .op_load_data, .redirect_valid, .redirect_addr, .store_valid,
		.store_data, .entry_busy, .irq);
	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic taken(int c);
		return c > 1;
	endfunction
	task give_verdict();
		if (n_errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task op(input sfi_op_e c, input logic [31:0] tg, input logic [31:0] pc);
		@(posedge hclk);
		op_valid <= 1;
		op_code <= c;
		op_target <= tg;
		cur_pc <= pc;
		@(posedge hclk);
		op_valid <= 0;
		#1;
		rv = redirect_valid;
		ra = redirect_addr;
		sv = store_valid;
		sd = store_data;
	endtask
	task wait_redir(input string nm, input logic [31:0] e);
		do @(posedge hclk); while (redirect_valid !== 1'b1);
		chk(nm, redirect_addr, e);
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		rdc("ctrl", OFS_CTRL, 32'h0);
		p = xs();
		t = xs();
		op(OP_CALL, t, p);
		chk("call", {rv, ra}, {1'b1, t});
		q = xs();
		op(OP_CALL, xs(), q);
		rdc("link", OFS_LINK, q + RET_STEP);
		op(OP_LINK_RET, 32'h0, p);
		chk("ret", {rv, ra}, {1'b1, q + RET_STEP});
		op(OP_NOP, t, p);
		chk("nop", rv, 1'b0);
		op(OP_JUMP, q, p);
		chk("jump", {rv, ra}, {1'b1, q});
		for (int n = 0; n < 2; n++) begin
			lc = 2 + int'(xs() % 3);
			bus(1, n ? OFS_LC1 : OFS_LC0, lc);
			for (int i = 0; i <= lc; i++) begin
				op(n ? OP_LOOP1_NE : OP_LOOP0_NE, t, p);
				chk("loop ne", rv, taken(lc - i));
			end
			rdc("lc", n ? OFS_LC1 : OFS_LC0, 32'h0);
			op(n ? OP_LOOP1_EX : OP_LOOP0_EX, t, p);
			chk("loop ex", rv, 1'b1);
			bus(1, n ? OFS_LC1 : OFS_LC0, 32'h1);
			op(n ? OP_LOOP1_EX : OP_LOOP0_EX, t, p);
			chk("loop ex1", rv, 1'b0);
		end
		rdc("evt", OFS_EVT_STAT, 32'h4);
		bus(1, OFS_EVT_STAT, 32'h4);
		rdc("evt clr", OFS_EVT_STAT, 32'h0);
		for (int i = 0; i < 30; i++) begin
			v[i] = xs() & 32'hffff_fffc;
			bus(1, OFS_VEC_BASE + 8'(4 * i), v[i]);
		end
		for (int i = 0; i < 30; i++) rdc("vec", OFS_VEC_BASE + 8'(4 * i), v[i]);
		bus(1, OFS_CTRL, 32'h3);
		bus(1, OFS_IRQ_EN, 32'h1fff_ffff);
		bus(1, OFS_EVT_MASK, 32'h1);
		k = 1 + int'(xs() % 28);
		@(posedge hclk);
		fire <= 1;
		idx <= 5'(k);
		@(posedge hclk);
		fire <= 0;
		wait_redir("hw vec", v[k]);
		rdc("iret", OFS_IRET, p);
		rdc("pm lo", OFS_PMASK_LO, 32'h1 << k);
		rdc("pm hi", OFS_PMASK_HI, 32'h1 << BLOCK_BIT_PMH);
		chk("irq", irq, 1'b1);
		@(posedge hclk);
		fire <= 1;
		idx <= 5'h0;
		@(posedge hclk);
		fire <= 0;
		repeat (8) @(posedge hclk);
		rdc("latch", OFS_LATCH_LO, 32'h1);
		op(OP_ALIAS_STORE, t, p);
		chk("store", {sv, sd}, {1'b1, p});
		wait_redir("nest vec", v[0]);
		q = xs();
		op_load_data <= q;
		op(OP_ALIAS_LOAD, t, p);
		rdc("iret ld", OFS_IRET, q);
		rdc("blk", OFS_PMASK_HI, 32'h1 << BLOCK_BIT_PMH);
		op(OP_RTI, t, p);
		chk("rti", {rv, ra}, {1'b1, q});
		rdc("pm rti", OFS_PMASK_LO, 32'h1 << k);
		op(OP_IRET_KEEP, t, p);
		chk("keep", {rv, ra}, {1'b1, q});
		rdc("pm keep", OFS_PMASK_LO, 32'h1 << k);
		op(OP_RDS, t, p);
		rdc("pm rds", OFS_PMASK_LO, 32'h0);
		bus(1, OFS_EVT_MASK, 32'h0);
		@(posedge hclk);
		chk("irq mask", irq, 1'b0);
		bus(1, OFS_EVT_MASK, 32'h1);
		@(posedge hclk);
		chk("irq unmask", irq, 1'b1);
		bus(1, OFS_EVT_STAT, 32'h1);
		@(posedge hclk);
		chk("irq clr", irq, 1'b0);
		bus(1, OFS_CTRL, 32'h6);
		p = xs();
		op(OP_SW_EXC, t, p);
		op(OP_ALIAS_STORE, t, p);
		chk("busy op", sv, 1'b0);
		wait_redir("sw vec", v[29]);
		rdc("sret", OFS_SRET, p);
		bus(0, OFS_SEQ_STAT, 32'h0);
		chk("sq", rd[SWEXC_BIT], 1'b1);
		q = xs();
		op_load_data <= q;
		op(OP_ALIAS_LOAD, t, p);
		bus(0, OFS_SEQ_STAT, 32'h0);
		chk("sq blk", rd[BLOCK_BIT_SQS], 1'b1);
		op(OP_ALIAS_STORE, t, p);
		chk("store sq", {sv, sd}, {1'b1, q});
		bus(0, OFS_SEQ_STAT, 32'h0);
		chk("sq clr", rd[BLOCK_BIT_SQS], 1'b0);
		give_verdict();
	end
endmodule
